//--- undertemp_protection_tb_top.sv
// Purpose: Self-checking bench of the undertemperature protection block
// Assumes: APB slave answers in the access cycle
// Notes: Thresholds drawn at random with fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "utp_regs.svh"
module undertemp_protection_tb_top;
   logic clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr, er;
   logic meas_valid, sleep_mode, burst, ts_meas, chg_sw, dsg_sw, stay, bias;
   logic [1:0] vsp, csp;
   logic [3:0] pstrb;
   logic [7:0] paddr, tc, td, rc, pc;
   logic [31:0] pwdata, prdata, rv, sp;
   logic [15:0] meas_data;
   logic [15:0] vt [6];
   int fail_count, checks;
   utp_sched_model sch (.clk_in(clk_sys_in), .valid_out(meas_valid), .data_out(meas_data),
      .ts_meas_out(ts_meas));
   utp_top dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .meas_valid_in(meas_valid), .meas_data_in(meas_data), .sleep_mode_in(sleep_mode),
      .burst_in(burst), .ts_measuring_in(ts_meas), .volt_speed_out(vsp), .curr_speed_out(csp),
      .charge_switch_out(chg_sw), .discharge_switch_out(dsg_sw), .stay_awake_out(stay),
      .bias_on_out(bias));
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   function automatic logic [15:0] cnt(input logic [7:0] s);
      return 16'({8'h00, s} * 16'h004d);
   endfunction
   function automatic logic [31:0] alerts(input logic [15:0] v, input logic [7:0] c, input logic [7:0] d);
      return {30'h0, v > cnt(d), v > cnt(c)};
   endfunction
   task automatic print_verdict;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         print_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rv, er);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, rv, er);
      chk(rv & m, exp);
   endtask
   // Registered pins need two further edges before they can be sampled
   task automatic settle;
      repeat (2) @(posedge clk_sys_in);
   endtask
   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      sleep_mode = 1'b0;
      burst = 1'b0;
      rst_in = 1'b1;
      fail_count = 0;
      checks = 0;
      void'($urandom(3));
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      rdc(`UTP_ADDR_CTRL, 32'hff, 32'h7c);
      settle();
      chk({dsg_sw, chg_sw}, 32'h3);
      apb(1'b0, 8'h20, 32'h0, rv, er);
      chk(er, 32'h1);
      chk(rv, 32'h0);
      apb(1'b1, 8'h24, 32'h0, rv, er);
      chk(er, 32'h1);
      rdc(`UTP_ADDR_CTRL, 32'hff, 32'h7c);
      tdone("reset");
      wr(`UTP_ADDR_CTRL, 32'h7f);
      sp = $urandom_range(0, 15);
      wr(`UTP_ADDR_SPEED, sp);
      settle();
      chk({csp, vsp}, sp);
      tdone("speed");
      tc = 8'($urandom_range(2, 254));
      td = 8'($urandom_range(1, 255));
      wr(`UTP_ADDR_THR, {td, tc});
      wr(`UTP_ADDR_PERSIST, 32'h0505);
      vt = '{cnt(tc), cnt(tc) + 16'h1, cnt(td), cnt(td) + 16'h1, 16'h0, 16'hffff};
      for (int i = 0; i < 6; i++) begin
         sch.send(vt[i]);
         rdc(`UTP_ADDR_STATUS, 32'h3, alerts(vt[i], tc, td));
         sch.send(16'h0);
      end
      pstrb <= 4'h1;
      wr(`UTP_ADDR_THR, 32'h0);
      pstrb <= 4'hf;
      rdc(`UTP_ADDR_THR, 32'hffff, {16'h0, td, 8'h00});
      tdone("threshold");
      pc = 8'($urandom_range(1, 4));
      rc = 8'($urandom_range(1, tc - 1));
      wr(`UTP_ADDR_THR, {8'hff, tc});
      wr(`UTP_ADDR_PERSIST, {8'h00, pc});
      wr(`UTP_ADDR_REC, {8'h00, rc});
      repeat (pc) sch.send(cnt(tc) + 16'h1);
      sch.send(cnt(tc));
      repeat (pc) sch.send(cnt(tc) + 16'h1);
      rdc(`UTP_ADDR_STATUS, 32'h5, 32'h1);
      sch.send(cnt(tc) + 16'h1);
      rdc(`UTP_ADDR_STATUS, 32'h15, 32'h4);
      sch.send(cnt(rc) + 16'h1);
      rdc(`UTP_ADDR_STATUS, 32'h5, 32'h4);
      sch.send(cnt(rc));
      rdc(`UTP_ADDR_STATUS, 32'h15, 32'h10);
      tdone("cold charge");
      sch.send(cnt(8'hff) + 16'h1);
      rdc(`UTP_ADDR_STATUS, 32'h2a, 32'h08);
      sch.send(16'h0);
      rdc(`UTP_ADDR_STATUS, 32'h2b, 32'h08);
      wr(`UTP_ADDR_CMD, 32'h049b);
      rdc(`UTP_ADDR_STATUS, 32'h2a, 32'h20);
      wr(`UTP_ADDR_CTRL, 32'h6f);
      sch.send(cnt(8'hff) + 16'h1);
      rdc(`UTP_ADDR_STATUS, 32'h28, 32'h28);
      wr(`UTP_ADDR_CMD, 32'h049b);
      sch.send(16'h0);
      wr(`UTP_ADDR_CTRL, 32'h7d);
      sch.send(cnt(8'hff) + 16'h1);
      rdc(`UTP_ADDR_STATUS, 32'h0b, 32'h01);
      sch.send(16'h0);
      tdone("cold discharge");
      chk(bias, 32'h0);
      pstrb <= 4'h1;
      wr(`UTP_ADDR_CMD, 32'h0169);
      pstrb <= 4'hf;
      chk(bias, 32'h0);
      wr(`UTP_ADDR_CMD, 32'h0169);
      chk(bias, 32'h1);
      rdc(`UTP_ADDR_SPEED, 32'h1f, 32'h10 | sp);
      wr(`UTP_ADDR_CMD, 32'h0069);
      chk(bias, 32'h0);
      tdone("bias");
      wr(`UTP_ADDR_CTRL, 32'h7f);
      wr(`UTP_ADDR_PERSIST, 32'h0505);
      sleep_mode <= 1'b1;
      sch.send(16'hffff);
      rdc(`UTP_ADDR_STATUS, 32'h3, 32'h0);
      rdc(`UTP_ADDR_READING, 32'hffff, 32'h0);
      burst <= 1'b1;
      sch.send(16'hffff);
      settle();
      chk(stay, 32'h1);
      rdc(`UTP_ADDR_STATUS, 32'h3, 32'h3);
      sch.send(16'h0);
      settle();
      chk(stay, 32'h0);
      tdone("sleep");
      print_verdict();
   end
endmodule
`default_nettype wire

//--- utp_chan_if.sv
// Purpose: Carrier between the register side and one protection channel
// Assumes: One instance per channel
// Notes: Counts are already scaled to reading codes
`timescale 1ns/1ps
`default_nettype none
interface utp_chan_if;
   logic en;
   logic [15:0] thr;
   logic [15:0] rec;
   logic [7:0] persist;
   logic eval;
   logic [15:0] sample;
   logic recover;
   logic alert;
   logic fault;
   modport ctrl(output en, thr, rec, persist, eval, sample, recover, input alert, fault);
   modport chan(input en, thr, rec, persist, eval, sample, recover, output alert, fault);
endinterface
`default_nettype wire

//--- utp_channel.sv
// Purpose: One undertemperature channel: alert, persistence count, fault and recovery
// Assumes: eval pulses once per accepted thermistor reading
// Notes: Fault needs persist+1 consecutive readings above threshold
`timescale 1ns/1ps
`default_nettype none
module utp_channel (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   utp_chan_if.chan ch
);
   utp_pkg::utp_state_t state;
   utp_pkg::utp_state_t next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   wire over = ch.sample > ch.thr;
   wire auto_rec = ch.eval && (ch.rec != 16'h0000) && (ch.sample <= ch.rec);

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         utp_pkg::UTP_NORMAL: begin
            next_cnt = 8'h00;
            if (ch.en && ch.eval && over) begin
               next_state = (ch.persist == 8'h00) ? utp_pkg::UTP_FAULT : utp_pkg::UTP_ALERT;
               next_cnt = 8'h01;
            end
         end
         utp_pkg::UTP_ALERT: begin
            if (!ch.en) begin
               next_state = utp_pkg::UTP_NORMAL;
               next_cnt = 8'h00;
            end else if (ch.eval && !over) begin
               next_state = utp_pkg::UTP_NORMAL;
               next_cnt = 8'h00;
            end else if (ch.eval && cnt == ch.persist) begin
               next_state = utp_pkg::UTP_FAULT;
               next_cnt = 8'h00;
            end else if (ch.eval) begin
               next_cnt = cnt + 8'h01;
            end
         end
         utp_pkg::UTP_FAULT: begin
            next_cnt = 8'h00;
            // Fault holds even with the channel disabled
            if (ch.recover || auto_rec) begin
               next_state = utp_pkg::UTP_NORMAL;
            end
         end
         default: begin
            next_state = utp_pkg::UTP_NORMAL;
            next_cnt = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state <= utp_pkg::UTP_NORMAL;
         cnt <= 8'h00;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   assign ch.alert = (state == utp_pkg::UTP_ALERT);
   assign ch.fault = (state == utp_pkg::UTP_FAULT);

   property p_alert_set;
      @(posedge clk_sys_in) disable iff (rst_in)
      (state == utp_pkg::UTP_NORMAL && ch.en && ch.eval && over && ch.persist != 8'h00) |=> ch.alert;
   endproperty
   a_alert_set: assert property (p_alert_set) else $error("alert not raised above threshold");
   property p_alert_clr;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ch.alert && ch.eval && !over) |=> (!ch.alert && !ch.fault);
   endproperty
   a_alert_clr: assert property (p_alert_clr) else $error("alert kept at or below threshold");
   property p_trip;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ch.alert && ch.en && ch.eval && over && cnt == ch.persist) |=> (ch.fault && !ch.alert);
   endproperty
   a_trip: assert property (p_trip) else $error("persistence did not trip");
   property p_cnt_reset;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ch.alert && ch.eval && !over) |=> (cnt == 8'h00);
   endproperty
   a_cnt_reset: assert property (p_cnt_reset) else $error("persistence count not reset");
   property p_auto_rec;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ch.fault && auto_rec) |=> !ch.fault;
   endproperty
   a_auto_rec: assert property (p_auto_rec) else $error("autonomous recovery missed");
   property p_host_rec;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ch.fault && ch.recover) |=> !ch.fault;
   endproperty
   a_host_rec: assert property (p_host_rec) else $error("host recovery missed");
   property p_fault_hold;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ch.fault && !ch.recover && !auto_rec) |=> (ch.fault && !ch.alert);
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without recovery");

   c_alert: cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(ch.alert));
   c_trip: cover property (@(posedge clk_sys_in) disable iff (rst_in) ch.alert ##1 ch.fault);
   c_recover: cover property (@(posedge clk_sys_in) disable iff (rst_in) $fell(ch.fault));
endmodule
`default_nettype wire

//--- utp_pkg.sv
// Purpose: Types and shared arithmetic of the undertemperature protection block
// Assumes: utp_regs.svh on the include path
// Notes: Nothing here holds state
`include "utp_regs.svh"
package utp_pkg;
   // Gray codes along normal, alert, fault
   typedef enum logic [1:0] {
      UTP_NORMAL = 2'b00,
      UTP_ALERT = 2'b01,
      UTP_FAULT = 2'b11
   } utp_state_t;

   // Step index to reading counts; 255 steps give 19635
   function automatic logic [15:0] utp_step_to_count(input logic [7:0] step);
      return 16'({8'h00, step} * `UTP_STEP_COUNTS);
   endfunction
endpackage

//--- utp_regs.svh
// Purpose: Register map, field positions and reset values of the undertemperature protection block
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: Thresholds are held as step indices; one step is a fixed count of reading codes
`ifndef UTP_REGS_SVH
`define UTP_REGS_SVH

`define UTP_ADDR_CTRL 8'h00
`define UTP_ADDR_THR 8'h04
`define UTP_ADDR_REC 8'h08
`define UTP_ADDR_PERSIST 8'h0c
`define UTP_ADDR_STATUS 8'h10
`define UTP_ADDR_CMD 8'h14
`define UTP_ADDR_READING 8'h18
`define UTP_ADDR_SPEED 8'h1c

`define UTP_CTRL_EN_CC 0
`define UTP_CTRL_EN_CD 1
`define UTP_CTRL_AUTO 2
`define UTP_CTRL_MASK_CHG 3
`define UTP_CTRL_MASK_DSG 4
`define UTP_CTRL_HOST_CHG 5
`define UTP_CTRL_HOST_DSG 6
`define UTP_CTRL_RST 7'h7c
`define UTP_THR_RST 8'h00
`define UTP_REC_RST 8'h00
`define UTP_PERSIST_RST 8'h00
`define UTP_SPEED_RST 4'h0

`define UTP_STEP_COUNTS 16'h004d
`define UTP_OP_REGOUT 8'h69
`define UTP_OP_RECOVERY 8'h9b
`define UTP_PAY_BIAS 0
`define UTP_PAY_TEMPERATURE_RECOVERY_REQUEST 2

`endif

//--- utp_sched_model.sv
// Purpose: Measurement scheduler model feeding thermistor readings
// Assumes: Calls start just after a rising edge
// Notes: Data line shows the inverse of the last reading outside a pulse
`timescale 1ns/1ps
`default_nettype none
module utp_sched_model (
   input wire logic clk_in,
   output logic valid_out,
   output logic [15:0] data_out,
   output logic ts_meas_out
);
   initial begin
      valid_out = 1'b0;
      data_out = 16'h5a5a;
      ts_meas_out = 1'b0;
   end
   // One pulse per reading, as the scheduler sends it
   task automatic send(input logic [15:0] v);
      valid_out <= 1'b1;
      data_out <= v;
      ts_meas_out <= 1'b1;
      @(posedge clk_in);
      valid_out <= 1'b0;
      data_out <= ~v;
      ts_meas_out <= 1'b0;
      @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

//--- utp_top.sv
// Purpose: Cold-charge and cold-discharge protection with APB registers and switch control
// Assumes: Readings come from the scheduler on this clock, one valid pulse per reading
// Notes: APB answers with no wait state; unmapped addresses give pslverr
`timescale 1ns/1ps
`default_nettype none
`include "utp_regs.svh"
// Behaviour
// - Cold-charge threshold 0..19635 in steps of 77
// - Cold-discharge threshold same range and step
// - Each channel has its own enable
// - Reading above threshold sets alert, or fault at once if persist count is zero
// - Reading at or below threshold clears alert
// - Cold-charge persists count readings, then faults
// - Cold-discharge persists own count, then faults
// - Trip clears alert, sets fault
// - Cold-charge fault opens charge switch if selected
// - Cold-discharge fault opens discharge switch if selected
// - Fault clears at or below recovery threshold
// - Recovery threshold 0..19635 in steps of 77
// - Zero recovery threshold needs host recovery command
// - Persistence counts scheduler readings at configured speeds
// - In sleep, evaluate only during bursts
// - Alert keeps device awake until cleared
// - Bias on while measuring or when forced
module utp_top (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic meas_valid_in,
   input wire logic [15:0] meas_data_in,
   input wire logic sleep_mode_in,
   input wire logic burst_in,
   input wire logic ts_measuring_in,
   output logic [1:0] volt_speed_out,
   output logic [1:0] curr_speed_out,
   output logic charge_switch_out,
   output logic discharge_switch_out,
   output logic stay_awake_out,
   output logic bias_on_out
);
   logic [6:0] ctrl;
   logic [7:0] cc_thr;
   logic [7:0] cd_thr;
   logic [7:0] cc_rec;
   logic [7:0] cd_rec;
   logic [7:0] cc_persist;
   logic [7:0] cd_persist;
   logic [3:0] speed;
   logic bias_always_on;
   logic [15:0] reading;
   logic [31:0] rdata;
   logic charge_switch;
   logic discharge_switch;
   logic stay_awake;
   logic next_charge_switch;
   logic next_discharge_switch;
   logic next_stay_awake;
   logic [31:0] next_rdata;

   utp_chan_if cc_if();
   utp_chan_if cd_if();

   // APB decode
   wire setup = psel_in && !penable_in;
   wire access = psel_in && penable_in;
   wire hit_ctrl = paddr_in == `UTP_ADDR_CTRL;
   wire hit_thr = paddr_in == `UTP_ADDR_THR;
   wire hit_rec = paddr_in == `UTP_ADDR_REC;
   wire hit_persist = paddr_in == `UTP_ADDR_PERSIST;
   wire hit_status = paddr_in == `UTP_ADDR_STATUS;
   wire hit_cmd = paddr_in == `UTP_ADDR_CMD;
   wire hit_reading = paddr_in == `UTP_ADDR_READING;
   wire hit_speed = paddr_in == `UTP_ADDR_SPEED;
   wire mapped = hit_ctrl || hit_thr || hit_rec || hit_persist || hit_status || hit_cmd || hit_reading
                 || hit_speed;
   wire wr = access && pwrite_in && mapped;
   wire wr_lo = wr && pstrb_in[0];
   wire wr_hi = wr && pstrb_in[1];

   // Commands run on the opcode byte; payload lane may be masked
   wire [7:0] cmd_payload = pstrb_in[1] ? pwdata_in[15:8] : 8'h00;
   wire cmd_regout = wr_lo && hit_cmd && pwdata_in[7:0] == `UTP_OP_REGOUT;
   wire cmd_recovery = wr_lo && hit_cmd && pwdata_in[7:0] == `UTP_OP_RECOVERY;
   wire temp_recovery = cmd_recovery && cmd_payload[`UTP_PAY_TEMPERATURE_RECOVERY_REQUEST];

   // Readings outside a sleep burst are ignored
   wire eval = meas_valid_in && (!sleep_mode_in || burst_in);

   wire auto_sw = ctrl[`UTP_CTRL_AUTO];
   wire [7:0] status = {bias_on_out, stay_awake, discharge_switch, charge_switch,
                        cd_if.fault, cc_if.fault, cd_if.alert, cc_if.alert};

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (1'b1)
         hit_ctrl: next_rdata = {25'h0000000, ctrl};
         hit_thr: next_rdata = {16'h0000, cd_thr, cc_thr};
         hit_rec: next_rdata = {16'h0000, cd_rec, cc_rec};
         hit_persist: next_rdata = {16'h0000, cd_persist, cc_persist};
         hit_status: next_rdata = {24'h000000, status};
         hit_reading: next_rdata = {16'h0000, reading};
         hit_speed: next_rdata = {27'h0000000, bias_always_on, speed};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Channel configuration
   assign cc_if.en = ctrl[`UTP_CTRL_EN_CC];
   assign cd_if.en = ctrl[`UTP_CTRL_EN_CD];
   assign cc_if.thr = utp_pkg::utp_step_to_count(cc_thr);
   assign cd_if.thr = utp_pkg::utp_step_to_count(cd_thr);
   assign cc_if.rec = utp_pkg::utp_step_to_count(cc_rec);
   assign cd_if.rec = utp_pkg::utp_step_to_count(cd_rec);
   assign cc_if.persist = cc_persist;
   assign cd_if.persist = cd_persist;
   assign cc_if.eval = eval;
   assign cd_if.eval = eval;
   assign cc_if.sample = meas_data_in;
   assign cd_if.sample = meas_data_in;
   assign cc_if.recover = temp_recovery;
   assign cd_if.recover = temp_recovery;

   utp_channel u_cold_charge_prot (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .ch(cc_if.chan)
   );

   utp_channel u_cold_discharge_prot (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .ch(cd_if.chan)
   );

   // Switch gating; the host enable alone never overrides a selected fault
   assign next_charge_switch = ctrl[`UTP_CTRL_HOST_CHG]
                               && !(auto_sw && ctrl[`UTP_CTRL_MASK_CHG] && cc_if.fault);
   assign next_discharge_switch = ctrl[`UTP_CTRL_HOST_DSG]
                                  && !(auto_sw && ctrl[`UTP_CTRL_MASK_DSG] && cd_if.fault);
   assign next_stay_awake = cc_if.alert || cd_if.alert;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ctrl <= `UTP_CTRL_RST;
      end else if (wr_lo && hit_ctrl) begin
         ctrl <= pwdata_in[6:0];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cc_thr <= `UTP_THR_RST;
         cc_rec <= `UTP_REC_RST;
         cc_persist <= `UTP_PERSIST_RST;
         speed <= `UTP_SPEED_RST;
      end else if (wr_lo) begin
         if (hit_thr) cc_thr <= pwdata_in[7:0];
         if (hit_rec) cc_rec <= pwdata_in[7:0];
         if (hit_persist) cc_persist <= pwdata_in[7:0];
         if (hit_speed) speed <= pwdata_in[3:0];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cd_thr <= `UTP_THR_RST;
         cd_rec <= `UTP_REC_RST;
         cd_persist <= `UTP_PERSIST_RST;
      end else if (wr_hi) begin
         if (hit_thr) cd_thr <= pwdata_in[15:8];
         if (hit_rec) cd_rec <= pwdata_in[15:8];
         if (hit_persist) cd_persist <= pwdata_in[15:8];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         bias_always_on <= 1'b0;
      end else if (cmd_regout) begin
         bias_always_on <= cmd_payload[`UTP_PAY_BIAS];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         reading <= 16'h0000;
      end else if (eval) begin
         reading <= meas_data_in;
      end
   end

   // Read data captured in setup so the access phase needs no wait
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rdata <= 32'h0000_0000;
      end else if (setup) begin
         rdata <= next_rdata;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         charge_switch <= 1'b0;
         discharge_switch <= 1'b0;
         stay_awake <= 1'b0;
      end else begin
         charge_switch <= next_charge_switch;
         discharge_switch <= next_discharge_switch;
         stay_awake <= next_stay_awake;
      end
   end

   assign prdata_out = rdata;
   assign pready_out = 1'b1;
   assign pslverr_out = access && !mapped;
   assign volt_speed_out = speed[1:0];
   assign curr_speed_out = speed[3:2];
   assign charge_switch_out = charge_switch;
   assign discharge_switch_out = discharge_switch;
   assign stay_awake_out = stay_awake;
   // Kept combinational so bias never lags the measurement window
   assign bias_on_out = bias_always_on || ts_measuring_in;

   property p_chg_off;
      @(posedge clk_sys_in) disable iff (rst_in)
      (cc_if.fault && auto_sw && ctrl[`UTP_CTRL_MASK_CHG]) |=> !charge_switch_out;
   endproperty
   a_chg_off: assert property (p_chg_off) else $error("charge switch left on in fault");
   property p_dsg_off;
      @(posedge clk_sys_in) disable iff (rst_in)
      (cd_if.fault && auto_sw && ctrl[`UTP_CTRL_MASK_DSG]) |=> !discharge_switch_out;
   endproperty
   a_dsg_off: assert property (p_dsg_off) else $error("discharge switch left on in fault");
   property p_awake;
      @(posedge clk_sys_in) disable iff (rst_in)
      (cc_if.alert || cd_if.alert) |=> stay_awake_out;
   endproperty
   a_awake: assert property (p_awake) else $error("alert did not hold device awake");
   property p_bias;
      @(posedge clk_sys_in) disable iff (rst_in)
      (cmd_regout && cmd_payload[`UTP_PAY_BIAS]) |=> bias_on_out [*2];
   endproperty
   a_bias: assert property (p_bias) else $error("bias not forced on");
   property p_sleep_gate;
      @(posedge clk_sys_in) disable iff (rst_in)
      (sleep_mode_in && !burst_in && !wr) |=> ($stable(cc_if.alert) && $stable(cd_if.alert));
   endproperty
   a_sleep_gate: assert property (p_sleep_gate) else $error("channel evaluated outside burst");
   property p_disabled;
      @(posedge clk_sys_in) disable iff (rst_in)
      (!ctrl[`UTP_CTRL_EN_CC] && !cc_if.fault) |=> !cc_if.alert;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled channel raised alert");

   // Register side, switch restore and pin checks
   property p_rdata_cap;
      @(posedge clk_sys_in) disable iff (rst_in)
      setup |=> (prdata_out == $past(next_rdata));
   endproperty
   a_rdata_cap: assert property (p_rdata_cap) else $error("read data not captured in setup");
   property p_bad_rd;
      @(posedge clk_sys_in) disable iff (rst_in)
      (setup && !mapped) |=> (prdata_out == 32'h0000_0000);
   endproperty
   a_bad_rd: assert property (p_bad_rd) else $error("unmapped read returned data");
   property p_bad_wr;
      @(posedge clk_sys_in) disable iff (rst_in)
      (access && pwrite_in && !mapped) |=> ($stable(ctrl) && $stable(speed));
   endproperty
   a_bad_wr: assert property (p_bad_wr) else $error("unmapped write changed a register");
   property p_cd_no_auto;
      @(posedge clk_sys_in) disable iff (rst_in)
      (cd_if.fault && cd_rec == 8'h00 && !temp_recovery) |=> cd_if.fault;
   endproperty
   a_cd_no_auto: assert property (p_cd_no_auto) else $error("discharge fault left with zero recovery");
   property p_chg_on;
      @(posedge clk_sys_in) disable iff (rst_in)
      (!cc_if.fault && ctrl[`UTP_CTRL_HOST_CHG]) |=> charge_switch_out;
   endproperty
   a_chg_on: assert property (p_chg_on) else $error("charge switch not restored");
   property p_dsg_on;
      @(posedge clk_sys_in) disable iff (rst_in)
      (!cd_if.fault && ctrl[`UTP_CTRL_HOST_DSG]) |=> discharge_switch_out;
   endproperty
   a_dsg_on: assert property (p_dsg_on) else $error("discharge switch not restored");
   property p_awake_clr;
      @(posedge clk_sys_in) disable iff (rst_in)
      !(cc_if.alert || cd_if.alert) |=> !stay_awake_out;
   endproperty
   a_awake_clr: assert property (p_awake_clr) else $error("device held awake without alert");
   property p_bias_clr;
      @(posedge clk_sys_in) disable iff (rst_in)
      (cmd_regout && !cmd_payload[`UTP_PAY_BIAS]) |=> (bias_on_out == ts_measuring_in);
   endproperty
   a_bias_clr: assert property (p_bias_clr) else $error("bias not released to measuring");
   property p_cd_disabled;
      @(posedge clk_sys_in) disable iff (rst_in)
      (!ctrl[`UTP_CTRL_EN_CD] && !cd_if.fault) |=> !cd_if.alert;
   endproperty
   a_cd_disabled: assert property (p_cd_disabled) else $error("disabled discharge channel raised alert");
   property p_speed_wr;
      @(posedge clk_sys_in) disable iff (rst_in)
      (wr_lo && hit_speed) |=> ({curr_speed_out, volt_speed_out} == $past(pwdata_in[3:0]));
   endproperty
   a_speed_wr: assert property (p_speed_wr) else $error("speed outputs not updated");
   property p_sleep_hold;
      @(posedge clk_sys_in) disable iff (rst_in)
      (meas_valid_in && sleep_mode_in && !burst_in) |=> $stable(reading);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("reading taken outside burst");
   property p_reading_cap;
      @(posedge clk_sys_in) disable iff (rst_in)
      eval |=> (reading == $past(meas_data_in));
   endproperty
   a_reading_cap: assert property (p_reading_cap) else $error("evaluated reading not kept");
   property p_ctrl_wr;
      @(posedge clk_sys_in) disable iff (rst_in)
      (wr_lo && hit_ctrl) |=> (ctrl == $past(pwdata_in[6:0]));
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");
   property p_cc_persist_wr;
      @(posedge clk_sys_in) disable iff (rst_in)
      (wr_lo && hit_persist) |=> (cc_persist == $past(pwdata_in[7:0]));
   endproperty
   a_cc_persist_wr: assert property (p_cc_persist_wr) else $error("charge persist count lost");
   property p_cd_persist_wr;
      @(posedge clk_sys_in) disable iff (rst_in)
      (wr_hi && hit_persist) |=> (cd_persist == $past(pwdata_in[15:8]));
   endproperty
   a_cd_persist_wr: assert property (p_cd_persist_wr) else $error("discharge persist count lost");

   c_chg_trip: cover property (@(posedge clk_sys_in) disable iff (rst_in) $fell(charge_switch_out));
   c_sleep_wake: cover property (@(posedge clk_sys_in) disable iff (rst_in) sleep_mode_in && $rose(stay_awake_out));
endmodule
`default_nettype wire
